// >>> verilog/crp_pkg.sv
// package of constants and types for the receive process data mapping block
`default_nettype none
package crp_pkg;
  localparam int          CRP_NUM_MAP      = 8;                 // receive mappings
  localparam int          CRP_MAX_ENT      = 15;                // entries 01h..0Fh
  localparam int          CRP_PAY_BITS     = 64;                // eight payload bytes
  localparam logic [15:0] CRP_COMM_BASE    = 16'h1400;          // communication parameter objects
  localparam logic [15:0] CRP_MAP_BASE     = 16'h1600;          // content mapping objects
  localparam logic [7:0]  CRP_COMM_NSUB    = 8'h02;             // subindex zero of 140Nh
  localparam logic [10:0] CRP_ID_BASE0     = 11'h200;           // fixed bases, mappings 1..4
  localparam logic [10:0] CRP_ID_STEP      = 11'h100;
  localparam int          CRP_VALID_BIT    = 31;                // cleared means valid
  localparam logic [7:0]  CRP_TT_SYNC_MAX  = 8'hf0;
  localparam logic [7:0]  CRP_TT_ASYNC_LO  = 8'hfe;
  localparam logic [7:0]  CRP_TT_RESET     = 8'hff;
  localparam logic [15:0] CRP_DUMMY_LO     = 16'h0002;
  localparam logic [15:0] CRP_DUMMY_HI     = 16'h0007;
  localparam logic [31:0] CRP_ABORT_LEN    = 32'h06040042;
  localparam logic [31:0] CRP_ABORT_STATE  = 32'h08000022;
  localparam logic [31:0] CRP_ABORT_SUB    = 32'h06090011;
  localparam logic [31:0] CRP_ABORT_RO     = 32'h06010002;
  localparam logic [31:0] CRP_ABORT_NOOBJ  = 32'h06020000;
  localparam int          CRP_FIFO_DEPTH   = 16;

  // network management states
  typedef enum logic [1:0] {CRP_NMT_PREOP = 2'h0, CRP_NMT_OP = 2'h1, CRP_NMT_STOP = 2'h2} crp_nmt_t;

  // received frame as it travels through the fifo
  typedef struct packed {
    logic [10:0] can_id;
    logic [3:0]  dlc;
    logic [63:0] data;
  } crp_frame_t;

  // configuration write request
  typedef struct packed {
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] value;
  } crp_cfg_t;

  // one committed field into the object dictionary
  typedef struct packed {
    logic [15:0] index;
    logic [7:0]  sub;
    logic [7:0]  bits;
    logic [31:0] value;
  } crp_obj_t;
endpackage
`default_nettype wire

// >>> verilog/crp_fifo.sv
// synchronous valid/ready fifo with parameter width and depth
`default_nettype none
module crp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,     // clock
  input  wire logic             resetn,   // async reset, low
  input  wire logic [WIDTH-1:0] in_data,  // write data
  input  wire logic             in_valid, // write request
  output logic                  in_ready, // not full
  output logic [WIDTH-1:0]      out_data, // head word
  output logic                  out_valid,// not empty
  input  wire logic             out_ready // head taken
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  wire              do_wr = in_valid && in_ready;
  wire              do_rd = out_valid && out_ready;

  // fill level after this cycle; ready is registered from it so the port leaves a flop
  assign next_count = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  assign out_valid  = (count != '0);
  assign out_data  = mem[rd_ptr];

  // storage, no reset needed on the array
  always_ff @(posedge mclk)
  begin
    if (do_wr)
      mem[wr_ptr] <= in_data;
  end

  // pointers and fill level
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      in_ready <= 1'b1;
    end
    else
    begin
      if (do_wr)
        wr_ptr <= wr_ptr + AW'(1);
      if (do_rd)
        rd_ptr <= rd_ptr + AW'(1);
      count    <= next_count;
      in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end
endmodule
`default_nettype wire

// >>> verilog/crp_rx_pdo.sv
// receive process data mapping engine with configuration port and fifo
// Behaviour
// R1: process data only in Operational; configure in Pre-Operational
// R2: eight mappings, at most eight payload bytes
// R3: shorter payloads accepted, only mapped bytes used
// R4: communication parameters per mapping, subindex zero count
// R5: mappings 1-4 fixed identifier, valid bit writable
// R6: mappings 5-8 identifier and valid writable
// R7: new identifier applied only after communication restart
// R8: types 00h-F0h buffered, committed on SYNC
// R9: types FEh/FFh commit at once; F1h-FDh reserved
// R10: mapping count zero disables the mapping
// R11: entries 01h-0Fh in order without gaps
// R12: entry is index, subindex, bit length
// R13: each field follows previous in payload
// R14: dummy indices 0002h-0007h skip payload bits
// R15: transmit copy and send moments may differ
// R16: overlong mapping refused with 06040042h
// R17: mapping writes in Operational refused, 08000022h
// R18: frames on invalid identifier ignored
// R19: pending synchronous data dropped leaving Operational
`default_nettype none
module crp_rx_pdo
  import crp_pkg::*;
(
  input  wire logic        mclk,        // 40 MHz clock
  input  wire logic        resetn,      // async reset, low
  input  wire logic [6:0]  node_id,     // node identifier
  input  wire crp_nmt_t    nmt_state,   // network state
  input  wire logic        comm_reset,  // restart communication pulse
  input  wire crp_frame_t  rx_frame,    // received frame
  input  wire logic        rx_valid,    // frame offered
  output logic             rx_ready,    // fifo has room
  input  wire logic        sync_pulse,  // SYNC received
  input  wire crp_cfg_t    cfg_wr,      // configuration write
  input  wire logic        cfg_valid,   // write strobe
  output logic             cfg_done,    // write answered
  output logic [31:0]      cfg_abort,   // abort code, zero on success
  output crp_obj_t         obj_out,     // committed field
  output logic             obj_valid    // field strobe
);
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_WALK = 3'b010, ST_FLUSH = 3'b100} crp_state_t;

  // per mapping configuration
  // R2: eight mapping tables
  logic [31:0] cob_cfg   [CRP_NUM_MAP];
  logic [31:0] cob_live  [CRP_NUM_MAP];
  logic [7:0]  tx_type   [CRP_NUM_MAP];
  logic [3:0]  map_count [CRP_NUM_MAP];
  logic [31:0] map_ent   [CRP_NUM_MAP][CRP_MAX_ENT];
  // synchronous hold buffers
  logic [63:0] held_data [CRP_NUM_MAP];
  logic [CRP_NUM_MAP-1:0] held;

  crp_state_t  state;
  logic [2:0]  cur_map;
  logic [3:0]  cur_ent;
  logic [6:0]  bit_pos;
  logic [63:0] cur_data;
  logic [2:0]  flush_map;
  logic        sync_pend;
  logic        walk_sync;   // walk was started by a SYNC flush

  // fifo between frame input and mapping engine
  crp_frame_t  head;
  logic        head_valid;
  logic        head_take;
  crp_fifo #(.WIDTH($bits(crp_frame_t)), .DEPTH(CRP_FIFO_DEPTH)) u_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .in_data   (rx_frame),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .out_data  (head),
    .out_valid (head_valid),
    .out_ready (head_take)
  );

  // dummy index test, used by the walk only; the length check counts dummy bits too
  function automatic logic is_dummy(input logic [15:0] idx);
    return (idx >= CRP_DUMMY_LO) && (idx <= CRP_DUMMY_HI);
  endfunction

  // identifier match per mapping against the live copy
  logic [CRP_NUM_MAP-1:0] hit;
  logic [2:0]             hit_idx;
  genvar g;
  generate
    for (g = 0; g < CRP_NUM_MAP; g++)
    begin : g_match
      // R18: invalid ignored
      // R10: zero count disables
      assign hit[g] = !cob_live[g][CRP_VALID_BIT] && (cob_live[g][10:0] == head.can_id) && (map_count[g] != 4'h0);
    end
  endgenerate
  always_comb
  begin
    hit_idx = 3'h0;
    for (int i = CRP_NUM_MAP - 1; i >= 0; i--)
      if (hit[i])
        hit_idx = 3'(i);
  end

  // decode of configuration write target
  // R4: per-mapping parameter objects
  wire [15:0] w_idx     = cfg_wr.index;
  wire        w_comm    = (w_idx[15:3] == CRP_COMM_BASE[15:3]);
  wire        w_map     = (w_idx[15:3] == CRP_MAP_BASE[15:3]);
  wire [2:0]  w_n       = w_idx[2:0];
  wire        w_fixed   = !w_n[2];
  wire        w_op      = (nmt_state == CRP_NMT_OP);
  wire        w_sub_ok  = w_comm ? (cfg_wr.sub >= 8'h01 && cfg_wr.sub <= CRP_COMM_NSUB)
                                 : (cfg_wr.sub <= 8'(CRP_MAX_ENT));

  // total mapped bits that would result from a write to a content object
  // wide enough for fifteen entries of 255 bits, so a long sum cannot wrap
  logic [11:0] new_len;
  always_comb
  begin
    logic [3:0] cnt;
    cnt     = (cfg_wr.sub == 8'h00) ? cfg_wr.value[3:0] : map_count[w_n];
    new_len = 12'h0;
    for (int e = 0; e < CRP_MAX_ENT; e++)
      if (4'(e) < cnt)
        new_len = new_len + ((cfg_wr.sub == 8'(e + 1)) ? {4'h0, cfg_wr.value[7:0]} : {4'h0, map_ent[w_n][e][7:0]});
  end
  // R16: length over eight bytes
  wire w_too_long = w_map && (new_len > 12'(CRP_PAY_BITS) || (cfg_wr.sub == 8'h00 && cfg_wr.value > 32'(CRP_MAX_ENT)));

  logic [31:0] w_abort;
  always_comb
  begin
    if (!(w_comm || w_map))
      w_abort = CRP_ABORT_NOOBJ;
    // R17: refused in Operational
    else if (w_op)
      w_abort = CRP_ABORT_STATE;
    else if (!w_sub_ok)
      w_abort = CRP_ABORT_SUB;
    else if (w_too_long)
      w_abort = CRP_ABORT_LEN;
    else
      w_abort = 32'h0;
  end
  wire w_ok = cfg_valid && (w_abort == 32'h0);

  // current entry of the walk
  wire [31:0] ent      = map_ent[cur_map][cur_ent];
  wire [7:0]  ent_bits = ent[7:0];
  wire [63:0] ent_val  = cur_data >> bit_pos;
  wire        walk_end = (cur_ent >= map_count[cur_map]) || ({2'b0, bit_pos} + {1'b0, ent_bits} > 9'(CRP_PAY_BITS));
  wire        run      = (nmt_state == CRP_NMT_OP);
  // R15: commit moment per type
  // R9: asynchronous types
  wire        head_async = (tx_type[hit_idx] >= CRP_TT_ASYNC_LO);
  // R8: synchronous types
  wire        head_sync  = (tx_type[hit_idx] <= CRP_TT_SYNC_MAX);

  // R1: frames processed only in Operational, taken from the fifo and dropped otherwise
  assign head_take = (state == ST_IDLE) && head_valid && !(sync_pend && run);

  // configuration storage and restart of live identifiers
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int m = 0; m < CRP_NUM_MAP; m++)
      begin
        cob_cfg[m]   <= {1'b1, 31'h0};
        cob_live[m]  <= {1'b1, 31'h0};
        tx_type[m]   <= CRP_TT_RESET;
        map_count[m] <= 4'h0;
        for (int e = 0; e < CRP_MAX_ENT; e++)
          map_ent[m][e] <= 32'h0;
      end
      cfg_done  <= 1'b0;
      cfg_abort <= 32'h0;
    end
    else
    begin
      cfg_done  <= cfg_valid;
      cfg_abort <= cfg_valid ? w_abort : cfg_abort;
      if (w_ok && w_comm && cfg_wr.sub == 8'h01)
      begin
        // R5: fixed base keeps only valid bit
        // R6: free identifier and valid
        if (w_fixed)
          cob_cfg[w_n] <= {cfg_wr.value[31], 20'h0, CRP_ID_BASE0 + 11'(w_n) * CRP_ID_STEP + {4'h0, node_id}};
        else
          cob_cfg[w_n] <= {cfg_wr.value[31], 20'h0, cfg_wr.value[10:0]};
      end
      if (w_ok && w_comm && cfg_wr.sub == 8'h02)
        tx_type[w_n] <= cfg_wr.value[7:0];
      // R11: entries stored by subindex
      if (w_ok && w_map && cfg_wr.sub == 8'h00)
        map_count[w_n] <= cfg_wr.value[3:0];
      if (w_ok && w_map && cfg_wr.sub != 8'h00)
        map_ent[w_n][cfg_wr.sub[3:0] - 4'h1] <= cfg_wr.value;
      // R7: identifier takes effect on restart
      if (comm_reset)
        for (int m = 0; m < CRP_NUM_MAP; m++)
          cob_live[m] <= (m < 4) ? {cob_cfg[m][31], 20'h0, CRP_ID_BASE0 + 11'(m) * CRP_ID_STEP + {4'h0, node_id}}
                                 : cob_cfg[m];
    end
  end

  // frame walk, sync flush and output strobe
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state     <= ST_IDLE;
      cur_map   <= 3'h0;
      cur_ent   <= 4'h0;
      bit_pos   <= 7'h0;
      cur_data  <= 64'h0;
      flush_map <= 3'h0;
      sync_pend <= 1'b0;
      walk_sync <= 1'b0;
      held      <= '0;
      obj_out   <= '0;
      obj_valid <= 1'b0;
      for (int m = 0; m < CRP_NUM_MAP; m++)
        held_data[m] <= 64'h0;
    end
    else
    begin
      obj_valid <= 1'b0;
      if (sync_pulse && run)
        sync_pend <= 1'b1;
      case (state)
        ST_IDLE:
        begin
          if (!run)
          begin
            // R19: drop uncommitted data
            held      <= '0;
            sync_pend <= 1'b0;
          end
          else if (sync_pend)
          begin
            state     <= ST_FLUSH;
            flush_map <= 3'h0;
            sync_pend <= sync_pulse;
          end
          else if (head_valid && |hit)
          begin
            // R3: only mapped bytes matter; dlc not checked
            if (head_async)
            begin
              state    <= ST_WALK;
              cur_map  <= hit_idx;
              walk_sync <= 1'b0;
              cur_ent  <= 4'h0;
              bit_pos  <= 7'h0;
              cur_data <= head.data;
            end
            else if (head_sync)
            begin
              held[hit_idx]      <= 1'b1;
              held_data[hit_idx] <= head.data;
            end
          end
        end
        ST_FLUSH:
        begin
          // R8: commit held data on SYNC
          if (held[flush_map])
          begin
            held[flush_map] <= 1'b0;
            state    <= ST_WALK;
            cur_map  <= flush_map;
            walk_sync <= 1'b1;
            cur_ent  <= 4'h0;
            bit_pos  <= 7'h0;
            cur_data <= held_data[flush_map];
          end
          else if (flush_map == 3'(CRP_NUM_MAP - 1))
            state <= ST_IDLE;
          else
            flush_map <= flush_map + 3'h1;
        end
        ST_WALK:
        begin
          if (walk_end || !run)
            // only a flush walk resumes the scan; an async walk must not commit held data
            state <= (walk_sync && run && cur_map != 3'(CRP_NUM_MAP - 1)) ? ST_FLUSH : ST_IDLE;
          else
          begin
            // R12: entry fields decoded
            // R14: dummy skips bits
            if (!is_dummy(ent[31:16]))
            begin
              obj_valid     <= 1'b1;
              obj_out.index <= ent[31:16];
              obj_out.sub   <= ent[15:8];
              obj_out.bits  <= ent_bits;
              obj_out.value <= ent_val[31:0] & ((ent_bits >= 8'd32) ? 32'hffffffff : ((32'h1 << ent_bits) - 32'h1));
            end
            // R13: next field follows
            bit_pos <= bit_pos + ent_bits[6:0];
            cur_ent <= cur_ent + 4'h1;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> bench/crp_can_node.sv
// bus node model that offers received frames to the block
`default_nettype none
module crp_can_node
  import crp_pkg::*;
(
  input  wire logic mclk,     // clock
  input  wire logic rx_ready, // block has room
  output crp_frame_t rx_frame, // offered frame
  output logic       rx_valid  // frame offered
);
  timeunit 1ns;
  timeprecision 100ps;

  int stuck; // offers that were never taken

  // idle bus at reset
  initial
  begin
    rx_frame = '0;
    rx_valid = 1'b0;
    stuck    = 0;
  end

  // one frame of eight bytes at most, held until taken or 500 cycles pass
  task automatic send(input crp_frame_t f);
    int n;
    n = 0;
    @(posedge mclk);
    rx_frame <= f;
    rx_valid <= 1'b1;
    @(posedge mclk);
    while (rx_ready !== 1'b1 && n < 500)
    begin
      n++;
      @(posedge mclk);
    end
    if (n >= 500)
      stuck++;
    rx_valid <= 1'b0;
    rx_frame <= ~f; // released data shows no stale value
  endtask
endmodule
`default_nettype wire

// >>> bench/crp_rx_pdo_chk.sv
// port assertions for the receive mapping block
`default_nettype none
module crp_rx_pdo_chk
  import crp_pkg::*;
(
  input wire logic        mclk,
  input wire logic        resetn,
  input wire crp_nmt_t    nmt_state,
  input wire logic        sync_pulse,
  input wire crp_cfg_t    cfg_wr,
  input wire logic        cfg_valid,
  input wire logic        cfg_done,
  input wire logic [31:0] cfg_abort,
  input wire crp_obj_t    obj_out,
  input wire logic        obj_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  // a walk may finish after leaving operational, so allow a margin
  logic [4:0] off_cnt;
  wire cfg_ok = cfg_valid && nmt_state != CRP_NMT_OP;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      off_cnt <= 5'h1f;
    else if (nmt_state == CRP_NMT_OP)
      off_cnt <= 5'h00;
    else if (off_cnt != 5'h1f)
      off_cnt <= off_cnt + 5'h01;
  end

  a_done_after_cfg: assert property (cfg_valid |=> cfg_done)
    else $error("config write not answered");
  a_done_has_cause: assert property (cfg_done |-> $past(cfg_valid))
    else $error("config answer without write");
  a_op_write_refused: assert property (cfg_valid && nmt_state == CRP_NMT_OP
    && cfg_wr.index inside {[16'h1400:16'h1407], [16'h1600:16'h1607]} |=> cfg_abort == CRP_ABORT_STATE)
    else $error("write in operational not refused");
  a_count_too_big: assert property (cfg_ok && cfg_wr.index inside {[16'h1600:16'h1607]} && cfg_wr.sub == 8'h00
    && cfg_wr.value > 32'd15 |=> cfg_abort == CRP_ABORT_LEN)
    else $error("oversized count accepted");
  a_no_object: assert property (cfg_ok && cfg_wr.index[15:12] != 4'h1 |=> cfg_abort == CRP_ABORT_NOOBJ)
    else $error("unknown object accepted");
  a_bad_comm_sub: assert property (cfg_ok && cfg_wr.index inside {[16'h1400:16'h1407]} && cfg_wr.sub > 8'h02
    |=> cfg_abort == CRP_ABORT_SUB)
    else $error("bad subindex accepted");
  a_abort_holds: assert property (!cfg_valid |=> $stable(cfg_abort))
    else $error("abort code changed without write");
  a_dummy_skipped: assert property (obj_valid |-> !(obj_out.index inside {[CRP_DUMMY_LO:CRP_DUMMY_HI]}))
    else $error("dummy target stored");
  a_quiet_off_op: assert property (off_cnt == 5'h1f |-> !obj_valid)
    else $error("field committed outside operational");

  c_obj: cover property (obj_valid);
  c_len: cover property (cfg_done && cfg_abort == CRP_ABORT_LEN);
  c_sync: cover property (sync_pulse ##[1:20] obj_valid);
endmodule

bind crp_rx_pdo crp_rx_pdo_chk u_chk (.mclk(mclk), .resetn(resetn), .nmt_state(nmt_state),
  .sync_pulse(sync_pulse), .cfg_wr(cfg_wr), .cfg_valid(cfg_valid), .cfg_done(cfg_done),
  .cfg_abort(cfg_abort), .obj_out(obj_out), .obj_valid(obj_valid));
`default_nettype wire

// >>> bench/crp_rx_pdo_tb_top.sv
// self-checking bench for the receive mapping block
`default_nettype none
module crp_rx_pdo_tb_top
  import crp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    crp_cfg_t    c;
    logic [31:0] ab;
  } crp_row_t;

  logic        mclk, resetn, comm_reset, rx_valid, rx_ready, sync_pulse, cfg_valid, cfg_done, obj_valid;
  logic [6:0]  node_id;
  logic [31:0] cfg_abort;
  crp_nmt_t    nmt_state;
  crp_frame_t  rx_frame;
  crp_cfg_t    cfg_wr;
  crp_obj_t    obj_out;
  crp_obj_t    got[$];
  int          n_fail, checked;
  logic        saw_full;
  // mapping 1 fills all eight bytes with a dummy gap; mapping 2 is valid with three entries but a count of zero
  crp_row_t rows[20] = '{{56'h1600_01_60400010, 32'h0}, {56'h1600_02_607a0020, 32'h0},
    {56'h1600_03_00050008, 32'h0}, {56'h1600_04_60600008, 32'h0}, {56'h1600_00_00000004, 32'h0},
    {56'h1400_01_00000777, 32'h0}, {56'h1400_02_000000fe, 32'h0}, {56'h1601_00_00000010, CRP_ABORT_LEN},
    {56'h2000_00_00000000, CRP_ABORT_NOOBJ}, {56'h1401_01_00000000, 32'h0},
    {56'h1601_01_60000020, 32'h0}, {56'h1601_02_60000020, 32'h0}, {56'h1601_03_60000020, 32'h0},
    {56'h1601_00_00000003, CRP_ABORT_LEN}, {56'h1400_03_00000000, CRP_ABORT_SUB},
    {56'h1408_01_00000000, CRP_ABORT_NOOBJ}, {56'h1604_01_20000108, 32'h0}, {56'h1604_00_00000001, 32'h0},
    {56'h1404_01_00000123, 32'h0}, {56'h1404_02_00000005, 32'h0}};
  crp_obj_t exp_a[3] = '{{16'h6040, 8'h00, 8'h10, 32'h00002211}, {16'h607a, 8'h00, 8'h20, 32'h66554433},
    {16'h6060, 8'h00, 8'h08, 32'h00000088}};
  crp_frame_t f1 = {11'h205, 4'h8, 64'h8877665544332211};
  crp_frame_t f5 = {11'h123, 4'h1, 64'ha5a5a5a5a5a5a55a};

  crp_rx_pdo uut (.mclk(mclk), .resetn(resetn), .node_id(node_id), .nmt_state(nmt_state),
    .comm_reset(comm_reset), .rx_frame(rx_frame), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .sync_pulse(sync_pulse), .cfg_wr(cfg_wr), .cfg_valid(cfg_valid), .cfg_done(cfg_done),
    .cfg_abort(cfg_abort), .obj_out(obj_out), .obj_valid(obj_valid));
  crp_can_node node (.mclk(mclk), .rx_ready(rx_ready), .rx_frame(rx_frame), .rx_valid(rx_valid));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // collect on the falling edge so registered strobes have settled
  always @(negedge mclk)
  begin
    if (obj_valid === 1'b1)
      got.push_back(obj_out);
    if (rx_ready === 1'b0)
      saw_full = 1'b1;
  end

  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d fails %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cfg(input crp_cfg_t c, input logic [31:0] ab);
    @(posedge mclk);
    cfg_wr <= c;
    cfg_valid <= 1'b1;
    @(posedge mclk);
    cfg_valid <= 1'b0;
    #1;
    chk(cfg_done === 1'b1 && cfg_abort === ab, "config answer");
    @(posedge mclk);
  endtask

  // waits for n fields, then a short quiet spell for extras; ends on a rising edge
  task automatic want(input int n, input string m);
    int i;
    i = 0;
    while (got.size() < n && i < 600)
    begin
      i++;
      @(negedge mclk);
    end
    repeat (8) @(negedge mclk);
    chk(got.size() == n, m);
    if (i >= 600 || node.stuck != 0)
    begin
      chk(1'b0, "wait timed out");
      stop_test();
    end
    $display("test %s done", m);
    @(posedge mclk);
  endtask

  task automatic pulse(input logic sync);
    @(posedge mclk);
    if (sync)
      sync_pulse <= 1'b1;
    else
      comm_reset <= 1'b1;
    @(posedge mclk);
    sync_pulse <= 1'b0;
    comm_reset <= 1'b0;
  endtask

  initial
  begin
    {resetn, comm_reset, sync_pulse, cfg_valid, saw_full} = '0;
    n_fail = 0;
    checked = 0;
    node_id = 7'h05;
    nmt_state = CRP_NMT_PREOP;
    cfg_wr = '0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    foreach (rows[k])
      cfg(rows[k].c, rows[k].ab);
    $display("test config rows done");
    nmt_state <= CRP_NMT_OP;
    node.send(f1);
    want(0, "identifier before restart");
    nmt_state <= CRP_NMT_PREOP;
    pulse(1'b0);
    nmt_state <= CRP_NMT_OP;
    repeat (40) node.send(f1);
    want(120, "async flood");
    chk(saw_full === 1'b1, "fifo never full");
    for (int k = 0; k < 3; k++)
      chk(got[k] === exp_a[k] && got[117 + k] === exp_a[k], "field content");
    got.delete();
    cfg({16'h1600, 8'h00, 32'h0}, CRP_ABORT_STATE);
    node.send(f5);
    want(0, "sync held");
    pulse(1'b1);
    want(1, "sync commit");
    chk(got[0] === {16'h2000, 8'h01, 8'h08, 32'h0000005a}, "short frame");
    got.delete();
    node.send(f5);
    repeat (6) @(posedge mclk);
    nmt_state <= CRP_NMT_PREOP;
    repeat (4) @(posedge mclk);
    nmt_state <= CRP_NMT_OP;
    pulse(1'b1);
    want(0, "sync dropped");
    node.send({11'h305, 4'h8, 64'h0});
    want(0, "disabled mapping");
    @(posedge mclk);
    resetn <= 1'b0;
    @(posedge mclk);
    #1;
    chk(rx_ready === 1'b1 && cfg_abort === 32'h0 && obj_valid === 1'b0, "reset values");
    @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk(cfg_done === 1'b0 && obj_valid === 1'b0 && rx_ready === 1'b1, "after release");
    node.send(f1);
    want(0, "identifiers invalid after reset");
    $display("test reset done");
    stop_test();
  end
endmodule
`default_nettype wire
